// [hw/tc3_timer.sv]
// module: timer control, counter, reload, capture and Wishbone register slave
//****************************************************************
// Function
// - high overflow flag sets when the high byte wraps, or the full 16-bit count wraps.
// - low overflow flag sets whenever the low byte wraps, in either mode.
// - hardware never clears either overflow flag; software clears by writing zero.
// - with the timer interrupt enabled, a set high overflow flag requests an interrupt.
// - with low-byte interrupt enable also set, the low overflow flag requests one too.
// - capture mode enable bit turns capture mode off at zero and on at one.
// - split bit selects one 16-bit auto-reload timer or two 8-bit ones.
// - run bit starts the timer; in split mode it gates only the high byte.
// - control bit 1 reads zero and ignores writes.
// - external select picks core clock divided by 12 or synced external clock by 8.
// - in split mode the external select serves both bytes unless a fast select overrides.
// - in capture mode each divided external falling edge copies counter to reload.
// - in 16-bit mode without capture the reload value is loaded when the counter wraps; with capture it wraps to zero.
// - a byte fast clock select of one picks the undivided core clock.
//****************************************************************
//
// Added by the designer: the Wishbone slave port.
`timescale 1ns/1ps
module tc3_timer
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [tc3_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic ext_clk_i,
    output logic irq_o
);
    import tc3_pkg::*;

    //****************************************************************
    // helpers
    //****************************************************************
    function automatic logic tc3_src(input logic fast, input logic xclk,
                                     input logic div_t, input logic ext_t);
        tc3_src = fast ? 1'b1 : (xclk ? ext_t : div_t);
    endfunction : tc3_src

    function automatic logic [7:0] tc3_merge(input logic [7:0] old, input logic [7:0] wd,
                                             input logic [7:0] mask);
        tc3_merge = (old & ~mask) | (wd & mask);
    endfunction : tc3_merge

    //****************************************************************
    // tick sources
    //****************************************************************
    tc3_tick_if ticks ();

    tc3_prescale #(.DIV(CORE_DIV)) u_pre (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick(ticks.pre_mp)
    );

    tc3_ext_sync #(.DIV(EXT_DIV)) u_ext (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ext_clk_i(ext_clk_i),
        .tick(ticks.ext_mp)
    );

    //****************************************************************
    // state
    //****************************************************************
    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic [7:0] aux_reg;
    logic [7:0] aux_next;
    logic [7:0] cntl_reg;
    logic [7:0] cntl_next;
    logic [7:0] cnth_reg;
    logic [7:0] cnth_next;
    logic [7:0] rll_reg;
    logic [7:0] rll_next;
    logic [7:0] rlh_reg;
    logic [7:0] rlh_next;
    logic ack_reg;
    logic ack_next;
    logic [31:0] dat_reg;
    logic [31:0] dat_next;

    logic split;
    logic run;
    logic capen;
    logic xclk;
    logic tick_l;
    logic tick_h;
    logic inc_l;
    logic inc_h;
    logic low_ovf;
    logic ovf16;
    logic high_ovf;
    logic cap;
    logic hit;
    logic wr;
    logic [7:0] idx;
    logic [7:0] wd;
    logic [7:0] rd_byte;

    //****************************************************************
    // counting
    //****************************************************************
    always_comb
    begin
        split = ctrl_reg[BIT_SPLIT];
        run = ctrl_reg[BIT_RUN];
        capen = ctrl_reg[BIT_CAPEN];
        xclk = ctrl_reg[BIT_XCLK];
        // 16-bit mode runs on the low byte's source
        tick_l = tc3_src(aux_reg[BIT_FASTL], xclk, ticks.div_tick, ticks.ext_fall);
        tick_h = tc3_src(aux_reg[BIT_FASTH], xclk, ticks.div_tick, ticks.ext_fall);
        inc_l = split ? tick_l : (run & tick_l);
        inc_h = split & run & tick_h;
        low_ovf = inc_l && (cntl_reg == BYTE_MAX);
        ovf16 = !split && low_ovf && (cnth_reg == BYTE_MAX);
        high_ovf = split ? (inc_h && (cnth_reg == BYTE_MAX)) : ovf16;
        cap = capen & ticks.ext_fall;
    end

    //****************************************************************
    // register bus
    //****************************************************************
    always_comb
    begin
        hit = wb_cyc_i & wb_stb_i;
        idx = wb_adr_i[ADR_W-1:2];
        wd = wb_dat_i[7:0];
        // a write lands on the edge that the master sees ack
        wr = hit & wb_we_i & ack_reg & wb_sel_i[0];
        ack_next = hit & ~ack_reg;
        unique case (idx)
            IDX_CTRL: rd_byte = ctrl_reg;
            IDX_RLL: rd_byte = rll_reg;
            IDX_RLH: rd_byte = rlh_reg;
            IDX_CNTL: rd_byte = cntl_reg;
            IDX_CNTH: rd_byte = cnth_reg;
            IDX_AUX: rd_byte = aux_reg;
            default: rd_byte = RST_BYTE;
        endcase
        dat_next = (hit & ~ack_reg) ? {24'h00_0000, rd_byte} : dat_reg;
    end

    //****************************************************************
    // next values
    //****************************************************************
    always_comb
    begin
        ctrl_next = ctrl_reg;
        aux_next = aux_reg;
        cntl_next = cntl_reg;
        cnth_next = cnth_reg;
        rll_next = rll_reg;
        rlh_next = rlh_reg;
        if (wr && idx == IDX_CTRL)
        begin
            ctrl_next = tc3_merge(ctrl_reg, wd, CTRL_WMASK);
        end
        if (wr && idx == IDX_AUX)
        begin
            aux_next = tc3_merge(aux_reg, wd, AUX_WMASK);
        end
        // hardware sets win over a software clear in the same cycle
        ctrl_next[BIT_TFH] = ctrl_next[BIT_TFH] | high_ovf | cap;
        ctrl_next[BIT_TFL] = ctrl_next[BIT_TFL] | low_ovf;
        if (inc_l)
        begin
            if (!low_ovf)
            begin
                cntl_next = cntl_reg + 8'h01;
            end
            else if (split || (ovf16 && !capen))
            begin
                cntl_next = rll_reg;
            end
            else
            begin
                cntl_next = RST_BYTE;
            end
        end
        if (!split && low_ovf)
        begin
            // capture mode lets the count run free instead of reloading
            if (!ovf16)
            begin
                cnth_next = cnth_reg + 8'h01;
            end
            else
            begin
                cnth_next = capen ? RST_BYTE : rlh_reg;
            end
        end
        else if (inc_h)
        begin
            cnth_next = (cnth_reg == BYTE_MAX) ? rlh_reg : cnth_reg + 8'h01;
        end
        if (wr && idx == IDX_CNTL)
        begin
            cntl_next = wd;
        end
        if (wr && idx == IDX_CNTH)
        begin
            cnth_next = wd;
        end
        if (wr && idx == IDX_RLL)
        begin
            rll_next = wd;
        end
        if (wr && idx == IDX_RLH)
        begin
            rlh_next = wd;
        end
        // a capture beats a software write of the reload bytes
        if (cap)
        begin
            rll_next = cntl_reg;
            rlh_next = cnth_reg;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_reg <= RST_BYTE;
            aux_reg <= RST_BYTE;
            cntl_reg <= RST_BYTE;
            cnth_reg <= RST_BYTE;
            rll_reg <= RST_BYTE;
            rlh_reg <= RST_BYTE;
            ack_reg <= 1'b0;
            dat_reg <= RST_WORD;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            aux_reg <= aux_next;
            cntl_reg <= cntl_next;
            cnth_reg <= cnth_next;
            rll_reg <= rll_next;
            rlh_reg <= rlh_next;
            ack_reg <= ack_next;
            dat_reg <= dat_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign irq_o = aux_reg[BIT_IEN] &
                   (ctrl_reg[BIT_TFH] | (ctrl_reg[BIT_TFLEN] & ctrl_reg[BIT_TFL]));

    //****************************************************************
    // checks
    //****************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic wr_ctrl;
    logic wr_cnt;
    assign wr_ctrl = wr && idx == IDX_CTRL;
    assign wr_cnt = wr && (idx == IDX_CNTL || idx == IDX_CNTH);
    property p_high_flag;
        high_ovf |=> ctrl_reg[BIT_TFH];
    endproperty
    a_high_flag : assert property (p_high_flag)
        else $error("high flag not set on overflow");

    property p_low_flag;
        low_ovf |=> ctrl_reg[BIT_TFL] ##1 (ctrl_reg[BIT_TFL] || $past(wr_ctrl));
    endproperty
    a_low_flag : assert property (p_low_flag)
        else $error("low flag not set on low byte wrap");

    property p_no_hw_clear;
        ctrl_reg[BIT_TFH] && !wr_ctrl |=> ctrl_reg[BIT_TFH];
    endproperty
    a_no_hw_clear : assert property (p_no_hw_clear)
        else $error("hardware cleared high flag");

    property p_irq_high;
        aux_reg[BIT_IEN] && $rose(ctrl_reg[BIT_TFH]) |-> irq_o;
    endproperty
    a_irq_high : assert property (p_irq_high)
        else $error("no interrupt on high flag");

    property p_irq_low;
        aux_reg[BIT_IEN] && ctrl_reg[BIT_TFLEN] && ctrl_reg[BIT_TFL] |-> irq_o;
    endproperty
    a_irq_low : assert property (p_irq_low)
        else $error("no interrupt on low flag");

    property p_capture;
        cap |=> {rlh_reg, rll_reg} == {$past(cnth_reg), $past(cntl_reg)} && ctrl_reg[BIT_TFH];
    endproperty
    a_capture : assert property (p_capture)
        else $error("capture did not copy counter");

    property p_reload16;
        ovf16 && !capen && !wr_cnt |=> {cnth_reg, cntl_reg} == {$past(rlh_reg), $past(rll_reg)};
    endproperty
    a_reload16 : assert property (p_reload16)
        else $error("reload not applied on 16-bit wrap");

    property p_split_low_runs;
        split && !run && tick_l && !wr_cnt && cntl_reg != BYTE_MAX
            |=> cntl_reg == $past(cntl_reg) + 8'h01;
    endproperty
    a_split_low_runs : assert property (p_split_low_runs)
        else $error("low byte stalled in split mode");

    property p_stopped;
        !split && !run && !wr_cnt |=> $stable(cntl_reg) && $stable(cnth_reg);
    endproperty
    a_stopped : assert property (p_stopped)
        else $error("counter moved while stopped");

    property p_unused_bit;
        ack_reg && $past(idx) == IDX_CTRL |-> wb_dat_o[1] == 1'b0;
    endproperty
    a_unused_bit : assert property (p_unused_bit)
        else $error("unused control bit read as one");

    property p_fast_tick;
        !split && run && aux_reg[BIT_FASTL] && !wr_cnt && cntl_reg != BYTE_MAX
            |=> cntl_reg == $past(cntl_reg) + 8'h01;
    endproperty
    a_fast_tick : assert property (p_fast_tick)
        else $error("fast select did not count every cycle");

    c_wrap16 : cover property (ovf16);
    c_split_high : cover property (split && high_ovf);
    c_capture : cover property (cap ##[1:100] cap);
endmodule : tc3_timer

// [hw/tc3_pkg.sv]
// package: register map, field positions, reset values and divider counts of the timer
package tc3_pkg;
    localparam int unsigned ADR_W = 10;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_CTRL = 8'h91;
    localparam logic [7:0] IDX_RLL = 8'h92;
    localparam logic [7:0] IDX_RLH = 8'h93;
    localparam logic [7:0] IDX_CNTL = 8'h94;
    localparam logic [7:0] IDX_CNTH = 8'h95;
    localparam logic [7:0] IDX_AUX = 8'h96;
    // control register fields
    localparam int unsigned BIT_TFH = 7;
    localparam int unsigned BIT_TFL = 6;
    localparam int unsigned BIT_TFLEN = 5;
    localparam int unsigned BIT_CAPEN = 4;
    localparam int unsigned BIT_SPLIT = 3;
    localparam int unsigned BIT_RUN = 2;
    localparam int unsigned BIT_XCLK = 0;
    localparam logic [7:0] CTRL_WMASK = 8'hFD;
    // auxiliary register fields
    localparam int unsigned BIT_IEN = 0;
    localparam int unsigned BIT_FASTL = 1;
    localparam int unsigned BIT_FASTH = 2;
    localparam logic [7:0] AUX_WMASK = 8'h07;
    // values after reset
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    // divider counts and byte maximum
    localparam int unsigned CORE_DIV = 12;
    localparam int unsigned EXT_DIV = 8;
    localparam logic [7:0] BYTE_MAX = 8'hFF;
endpackage : tc3_pkg

// [hw/tc3_tick_if.sv]
// interface: clock-source ticks passed from the dividers to the timer core
`timescale 1ns/1ps
interface tc3_tick_if;
    logic div_tick;
    logic ext_fall;
    modport pre_mp (output div_tick);
    modport ext_mp (output ext_fall);
    modport core_mp (input div_tick, input ext_fall);
endinterface : tc3_tick_if

// [hw/tc3_prescale.sv]
// module: core clock divided by twelve, one-cycle tick
`timescale 1ns/1ps
module tc3_prescale
    import tc3_pkg::*;
#(
    parameter int unsigned DIV = CORE_DIV
)(
    input wire logic clk_i,
    input wire logic rst_i,
    tc3_tick_if.pre_mp tick
);
    localparam int unsigned CW = $clog2(DIV);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic tick_reg;
    logic tick_next;

    always_comb
    begin
        cnt_next = (cnt_reg == LAST) ? '0 : cnt_reg + 1'b1;
        tick_next = (cnt_reg == LAST);
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt_reg <= '0;
            tick_reg <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tick.div_tick = tick_reg;

    property p_tick_phase;
        @(posedge clk_i) disable iff (rst_i)
        tick_reg |-> cnt_reg == '0;
    endproperty
    a_tick_phase : assert property (p_tick_phase)
        else $error("prescaler tick out of phase with its count");
endmodule : tc3_prescale

// [hw/tc3_ext_sync.sv]
// module: external clock synchroniser, divide by eight, falling-edge pulse
`timescale 1ns/1ps
module tc3_ext_sync
    import tc3_pkg::*;
#(
    parameter int unsigned DIV = EXT_DIV
)(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ext_clk_i,
    tc3_tick_if.ext_mp tick
);
    localparam int unsigned CW = $clog2(DIV);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);
    logic meta_reg;
    logic sync_reg;
    logic prev_reg;
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic fall_reg;
    logic fall_next;
    logic rise;

    // the external clock must stay below half the core clock
    always_comb
    begin
        rise = sync_reg & ~prev_reg;
        cnt_next = rise ? cnt_reg + 1'b1 : cnt_reg;
        // divided clock is cnt msb; it falls when the count wraps
        fall_next = rise && (cnt_reg == LAST);
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            prev_reg <= 1'b0;
            cnt_reg <= '0;
            fall_reg <= 1'b0;
        end
        else
        begin
            meta_reg <= ext_clk_i;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
            cnt_reg <= cnt_next;
            fall_reg <= fall_next;
        end
    end

    assign tick.ext_fall = fall_reg;

    property p_single_pulse;
        @(posedge clk_i) disable iff (rst_i)
        fall_reg |=> !fall_reg;
    endproperty
    a_single_pulse : assert property (p_single_pulse)
        else $error("capture pulse longer than one cycle");
endmodule : tc3_ext_sync

// [test/tc3_timer_tb_top.sv]
// testbench: register access, clock sources, overflow, interrupt and capture of the timer
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tc3_timer_tb_top;
    import tc3_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [ADR_W-1:0] wb_adr = '0;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat = 32'h0;
    logic ext_clk = 1'b0;
    logic ext_on = 1'b0;
    logic [1:0] ext_cnt = 2'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic irq_o;
    int n_mismatch = 0;
    int compares = 0;
    int seed = 11831;
    logic [7:0] q;
    logic [7:0] r1;
    logic [7:0] r2;
    logic [7:0] rl;
    logic [15:0] c1;

    tc3_timer dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_clk_i(ext_clk), .irq_o(irq_o));

    initial
    begin
        forever #5 clk_i = ~clk_i;
    end

    // external clock of eight core cycles, stands still while disabled
    always @(posedge clk_i)
    begin
        if (ext_on)
        begin
            ext_cnt <= ext_cnt + 2'h1;
            if (ext_cnt == 2'h3)
                ext_clk <= ~ext_clk;
        end
    end

    //****************************************************************
    // tasks
    //****************************************************************
    task automatic conclude;
        $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : conclude

    // ack is sampled at the edge itself; the request stands until that edge
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
        input logic [3:0] s, output logic [7:0] o);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= {idx, 2'b00};
        wb_sel <= s;
        wb_dat <= {24'h0, d};
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && n < 50)
        begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 50)
        begin
            n_mismatch++;
            conclude();
        end
        o = wb_dat_o[7:0];
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        // one more edge so the landed write is visible to the caller
        @(posedge clk_i);
    endtask : bus

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] o;
        bus(1'b1, idx, d, 4'hF, o);
    endtask : wr

    task automatic rd(input logic [7:0] idx, output logic [7:0] o);
        bus(1'b0, idx, 8'h00, 4'hF, o);
    endtask : rd

    // counts ticks over a window; prescaler phase is unknown, hence the tolerance
    task automatic rate(input logic [7:0] c, input int cyc);
        wr(IDX_CTRL, 8'h00);
        wr(IDX_CNTL, 8'h00);
        wr(IDX_CNTH, 8'h00);
        wr(IDX_CTRL, c);
        repeat (cyc) @(posedge clk_i);
        rd(IDX_CNTL, q);
        `CHK(q >= 8'h09 && q <= 8'h0B, 1'b1)
        rd(IDX_CNTH, q);
        `CHK(q, 8'h00)
    endtask : rate

    task automatic wait_flag;
        int n;
        n = 0;
        rd(IDX_CTRL, q);
        while (q[BIT_TFH] !== 1'b1 && n < 60)
        begin
            rd(IDX_CTRL, q);
            n++;
        end
        if (n >= 60)
        begin
            n_mismatch++;
            conclude();
        end
    endtask : wait_flag

    //****************************************************************
    // main sequence
    //****************************************************************
    initial
    begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 6; i++)
        begin
            rd(8'(IDX_CTRL + i), q);
            `CHK(q, RST_BYTE)
        end
        rl = 8'({$random(seed)} % 145);
        wr(rl, 8'hFF);
        rd(rl, q);
        `CHK(q, 8'h00)
        wr(IDX_AUX, 8'hFF);
        rd(IDX_AUX, q);
        `CHK(q, AUX_WMASK & 8'hFF)
        wr(IDX_AUX, 8'h00);
        $display("test reset_map done");
        for (int i = 0; i < 8; i++)
        begin
            r1 = 8'($random(seed));
            wr(IDX_CTRL, r1);
            rd(IDX_CTRL, q);
            `CHK(q, r1 & CTRL_WMASK)
        end
        bus(1'b1, IDX_CTRL, ~q, 4'hE, r2);
        rd(IDX_CTRL, r2);
        `CHK(r2, q)
        $display("test ctrl_access done");
        rate(8'h04, 120);
        ext_on <= 1'b1;
        rate(8'h05, 640);
        rd(IDX_CTRL, q);
        `CHK(q, 8'h05)
        rd(IDX_RLL, q);
        `CHK(q, 8'h00)
        $display("test clock_source done");
        // capture period is eight external periods of eight core cycles
        wr(IDX_AUX, 8'h02);
        wr(IDX_CTRL, 8'h14);
        for (int i = 0; i < 2; i++)
        begin
            wr(IDX_CTRL, 8'h14);
            wait_flag();
            `CHK(irq_o, 1'b0)
            rd(IDX_RLL, r1);
            rd(IDX_RLH, r2);
            if (i == 0)
                c1 = {r2, r1};
        end
        `CHK({r2, r1} - c1, 16'h0040)
        ext_on <= 1'b0;
        $display("test capture done");
        wr(IDX_CTRL, 8'h00);
        wr(IDX_AUX, 8'h03);
        wr(IDX_CNTH, 8'h5A);
        wr(IDX_RLL, 8'hF0);
        wr(IDX_CNTL, 8'hF0);
        wr(IDX_CTRL, 8'h08);
        repeat (40) @(posedge clk_i);
        rd(IDX_CTRL, q);
        `CHK(q, 8'h48)
        `CHK(irq_o, 1'b0)
        rd(IDX_CNTH, q);
        `CHK(q, 8'h5A)
        wr(IDX_CTRL, 8'h68);
        `CHK(irq_o, 1'b1)
        rl = 8'($random(seed));
        wr(IDX_RLH, rl);
        wr(IDX_CNTH, 8'hF8);
        wr(IDX_AUX, 8'h05);
        wr(IDX_CTRL, 8'h0C);
        repeat (20) @(posedge clk_i);
        rd(IDX_CTRL, q);
        `CHK(q & 8'h80, 8'h80)
        `CHK(irq_o, 1'b1)
        $display("test split done");
        wr(IDX_CTRL, 8'h00);
        wr(IDX_AUX, 8'h03);
        rl = 8'($random(seed));
        wr(IDX_RLL, rl & 8'h7F);
        wr(IDX_RLH, rl);
        wr(IDX_CNTL, 8'hFE);
        wr(IDX_CNTH, 8'hFF);
        wr(IDX_CTRL, 8'h04);
        rd(IDX_CTRL, q);
        `CHK(q, 8'hC4)
        rd(IDX_CNTH, q);
        `CHK(q, rl)
        `CHK(irq_o, 1'b1)
        wr(IDX_CTRL, 8'hC0);
        repeat (100) @(posedge clk_i);
        rd(IDX_CTRL, q);
        `CHK(q, 8'hC0)
        wr(IDX_CTRL, 8'h00);
        rd(IDX_CTRL, q);
        `CHK(q, 8'h00)
        `CHK(irq_o, 1'b0)
        $display("test wrap_reload done");
        conclude();
    end
endmodule : tc3_timer_tb_top
